//--- design/bxh_pkg.sv
package bxh_pkg;

  // Program storage address and data widths
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 16;

  // Instruction field positions
  localparam int OP_MSB = 15;
  localparam int OP_LSB = 13;
  localparam int SEL_MSB = 12;
  localparam int SEL_LSB = 8;
  localparam int LEN_MSB = 7;
  localparam int LEN_LSB = 5;
  localparam int LIT8_MSB = 7;
  localparam int LIT5_MSB = 4;
  localparam int SEL_IO_BIT = 4;
  localparam int SEL_POS_MSB = 2;

  // Widths of the low-bit substitution
  localparam int REG_SPAN_W = 8;
  localparam int IO_SPAN_W = 5;

  // Reset values and counter step
  localparam logic [ADDR_W-1:0] PC_RST = 13'h0000;
  localparam logic [ADDR_W-1:0] AR_RST = 13'h0000;
  localparam logic [ADDR_W-1:0] PC_STEP = 13'h0001;

  // Pin synchroniser depth
  localparam int SYNC_DEPTH = 3;

  typedef enum logic [2:0] {
    OP_MOVE = 3'h0,
    OP_ADD = 3'h1,
    OP_AND = 3'h2,
    OP_XOR = 3'h3,
    OP_XEC = 3'h4,
    OP_NZT = 3'h5,
    OP_TRANSMIT_LITERAL = 3'h6,
    OP_JMP = 3'h7
  } bxh_op_t;

  typedef struct packed {
    logic is_xec;
    logic is_nzt;
    logic is_transmit_literal;
    logic is_jmp;
    logic sel_io;
    logic [4:0] sel;
    logic [2:0] len;
    logic [DATA_W-1:0] lit;
    logic [ADDR_W-1:0] target;
  } bxh_dec_t;

  typedef struct packed {
    logic valid;
    logic io;
    logic [4:0] dest;
    logic [2:0] len;
    logic [DATA_W-1:0] data;
  } bxh_wr_t;

  // Length code zero means a full byte
  function automatic logic [DATA_W-1:0] bxh_len_mask(input logic [2:0] len);
    logic [DATA_W:0] one_hot;
    one_hot = 9'h001 << len;
    bxh_len_mask = (len == 3'h0) ? 8'hff : 8'(one_hot - 9'h001);
  endfunction

endpackage

//--- design/bxh_decode.sv
`timescale 1ns/1ps
module bxh_decode
  import bxh_pkg::*;
(
  // Instruction word
  input wire logic [INSTR_W-1:0] i_instr,
  // Decoded fields
  output bxh_pkg::bxh_dec_t o_dec
);
  import bxh_pkg::*;

  wire logic [2:0] op;
  wire logic sel_io;

  assign op = i_instr[OP_MSB:OP_LSB];
  assign sel_io = i_instr[SEL_LSB + SEL_IO_BIT];

  assign o_dec.is_xec = (op == OP_XEC);
  assign o_dec.is_nzt = (op == OP_NZT);
  assign o_dec.is_transmit_literal = (op == OP_TRANSMIT_LITERAL);
  assign o_dec.is_jmp = (op == OP_JMP);
  assign o_dec.sel_io = sel_io;
  assign o_dec.sel = i_instr[SEL_MSB:SEL_LSB];
  assign o_dec.len = i_instr[LEN_MSB:LEN_LSB];
  // Literal is 5 bits wide when an I/O field is named
  assign o_dec.lit = sel_io ? {3'h0, i_instr[LIT5_MSB:0]}
                            : i_instr[LIT8_MSB:0];
  assign o_dec.target = i_instr[ADDR_W-1:0];

endmodule // bxh_decode

//--- design/bxh_field.sv
`timescale 1ns/1ps
module bxh_field
  import bxh_pkg::*;
(
  // Raw source byte and field selection
  input wire logic [DATA_W-1:0] i_raw,
  input wire logic i_io,
  input wire logic [2:0] i_pos,
  input wire logic [2:0] i_len,
  // Right-justified source value
  output logic [DATA_W-1:0] o_value,
  output logic o_nonzero
);
  import bxh_pkg::*;

  wire logic [DATA_W-1:0] shifted;

  assign shifted = i_raw >> i_pos;
  // I/O source only: leading zeros above the field length; a register byte passes whole
  assign o_value = i_io ? (shifted & bxh_len_mask(i_len)) : i_raw;
  assign o_nonzero = |o_value;

endmodule // bxh_field

//--- design/bxh_flow.sv
`timescale 1ns/1ps
module bxh_flow
  import bxh_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // Halt pin, active low
  input wire logic i_halt_n,
  // Program storage
  input wire logic [INSTR_W-1:0] i_instr,
  output logic [ADDR_W-1:0] o_addr,
  // Source data for the current instruction
  input wire logic [DATA_W-1:0] i_src_raw,
  // Destination write
  output bxh_pkg::bxh_wr_t o_wr,
  // Status
  output logic o_mclk,
  output logic o_halted,
  output logic [ADDR_W-1:0] o_pc
);
  import bxh_pkg::*;

  typedef enum logic [2:0] {
    ST_PRIME = 3'b001,
    ST_RUN = 3'b010,
    ST_XEC = 3'b100
  } bxh_state_t;

  bxh_state_t state;
  bxh_state_t next_state;
  bxh_dec_t dec;
  logic [SYNC_DEPTH-1:0] halt_sync;
  logic halt_level;
  wire logic next_halt_level;
  logic [ADDR_W-1:0] pc;
  logic [ADDR_W-1:0] next_pc;
  logic [ADDR_W-1:0] next_ar;
  bxh_wr_t next_wr;
  wire logic [DATA_W-1:0] src_value;
  wire logic src_nonzero;
  wire logic exec;
  wire logic [DATA_W-1:0] xec_sum;
  wire logic [ADDR_W-1:0] xec_addr;
  wire logic [ADDR_W-1:0] nzt_pc;
  wire logic [ADDR_W-1:0] seq_pc;
  wire logic nzt_taken;

  bxh_decode u_decode (
    .i_instr(i_instr),
    .o_dec(dec)
  );

  bxh_field u_field (
    .i_raw(i_src_raw),
    .i_io(dec.sel_io),
    .i_pos(dec.sel[SEL_POS_MSB:0]),
    .i_len(dec.len),
    .o_value(src_value),
    .o_nonzero(src_nonzero)
  );

  // Halt pin crosses in from outside; stage one is read only by stage two
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      halt_sync <= '0;
    else
      halt_sync <= {halt_sync[SYNC_DEPTH-2:0], ~i_halt_n};
  end

  // Level changes only once the last two stages agree
  assign next_halt_level = (halt_sync[1] == halt_sync[2]) ? halt_sync[2]
                                                          : halt_level;

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      halt_level <= 1'b0;
    else
      halt_level <= next_halt_level;
  end

  // Whole cycles only: a cycle runs or is skipped, never split
  assign exec = (state != ST_PRIME) && !halt_level;

  assign xec_sum = 8'(dec.lit + src_value);
  assign xec_addr = dec.sel_io
    ? {o_addr[ADDR_W-1:IO_SPAN_W], xec_sum[IO_SPAN_W-1:0]}
    : {o_addr[ADDR_W-1:REG_SPAN_W], xec_sum};
  assign nzt_taken = dec.is_nzt && src_nonzero;
  assign nzt_pc = dec.sel_io
    ? {pc[ADDR_W-1:IO_SPAN_W], dec.lit[IO_SPAN_W-1:0]}
    : {pc[ADDR_W-1:REG_SPAN_W], dec.lit};
  assign seq_pc = 13'(pc + PC_STEP);

  // Flow: the program counter keeps the indirect's own address meanwhile
  always_comb
  begin
    next_state = state;
    next_pc = pc;
    next_ar = o_addr;
    case (state)
      ST_PRIME:
      begin
        next_state = ST_RUN;
      end
      ST_RUN, ST_XEC:
      begin
        if (exec)
        begin
          next_state = ST_RUN;
          if (dec.is_jmp)
          begin
            next_pc = dec.target;
            next_ar = dec.target;
          end
          else if (nzt_taken)
          begin
            next_pc = nzt_pc;
            next_ar = nzt_pc;
          end
          else if (dec.is_xec)
          begin
            next_ar = xec_addr;
            next_state = ST_XEC;
          end
          else
          begin
            next_pc = seq_pc;
            next_ar = seq_pc;
          end
        end
      end
      default:
      begin
        next_state = ST_PRIME;
      end
    endcase
  end

  // Destination write for transmit-literal
  always_comb
  begin
    next_wr = '0;
    next_wr.valid = exec && dec.is_transmit_literal;
    next_wr.io = dec.sel_io;
    next_wr.dest = dec.sel;
    next_wr.len = dec.len;
    // I/O literal is already 5 bits; the field length trims it further
    next_wr.data = dec.sel_io ? (dec.lit & bxh_len_mask(dec.len))
                              : dec.lit;
  end

  // Counter and address register reset to zero, state to ST_PRIME
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      pc <= PC_RST;
      o_addr <= AR_RST;
      state <= ST_PRIME;
    end
    else
    begin
      pc <= next_pc;
      o_addr <= next_ar;
      state <= next_state;
    end
  end

  // Write strobe: every field reloads each cycle, valid is cleared unless executing a transmit-literal
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_wr <= '0;
    else
      o_wr <= next_wr;
  end

  // Master clock is held low in reset and toggles otherwise, halted or not
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_mclk <= 1'b0;
    else
      o_mclk <= ~o_mclk;
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_halted <= 1'b0;
      o_pc <= PC_RST;
    end
    else
    begin
      // Same value as the internal level, so the flag names the live cycle
      o_halted <= next_halt_level;
      o_pc <= next_pc;
    end
  end

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_exec_jump;
    exec && dec.is_jmp;
  endsequence

  sequence s_exec_xec;
    exec && dec.is_xec && !dec.is_jmp;
  endsequence

  sequence s_exec_plain;
    exec && (state == ST_RUN) && !dec.is_jmp && !nzt_taken && !dec.is_xec;
  endsequence

  a_jump_loads_both: assert property (s_exec_jump |=>
    (pc == $past(dec.target)) && (o_addr == $past(dec.target)))
    else $error("Jump did not load counter and address");

  a_nzt_taken_low: assert property (exec && nzt_taken && !dec.is_jmp |=>
    (pc == $past(nzt_pc)) &&
    (pc[ADDR_W-1:REG_SPAN_W] == $past(pc[ADDR_W-1:REG_SPAN_W])))
    else $error("Taken branch changed wrong counter bits");

  a_nzt_not_taken: assert property (exec && dec.is_nzt && !src_nonzero |=>
    pc == 13'($past(pc) + PC_STEP))
    else $error("Untaken branch did not advance counter");

  a_xec_hold_pc: assert property (s_exec_xec |=>
    (pc == $past(pc)) && (state == ST_XEC))
    else $error("Indirect execute moved the counter");

  a_xec_target: assert property (s_exec_xec ##0 !dec.sel_io |=>
    o_addr[REG_SPAN_W-1:0] == 8'($past(dec.lit) + $past(src_value)))
    else $error("Indirect target address wrong");

  a_xec_io_span: assert property (s_exec_xec ##0 dec.sel_io |=>
    o_addr[ADDR_W-1:IO_SPAN_W] == $past(o_addr[ADDR_W-1:IO_SPAN_W]))
    else $error("Indirect on I/O field changed high bits");

  a_xec_return: assert property (s_exec_xec ##1 (exec && !dec.is_jmp &&
    !nzt_taken && !dec.is_xec) |=> pc == 13'($past(pc, 2) + PC_STEP))
    else $error("No return after indirect execute");

  a_halt_freeze: assert property (halt_level [*2] |->
    $stable(pc) && $stable(o_addr) && (o_mclk != $past(o_mclk)))
    else $error("Halt did not freeze state or stopped clock");

  a_halt_resume: assert property ($fell(halt_level) ##0 s_exec_plain |=>
    (pc == 13'($past(pc) + PC_STEP)))
    else $error("No execution after halt release");

  a_halt_flag: assert property (o_halted == halt_level)
    else $error("Halt flag differs from halt level");

  a_halt_no_write: assert property (halt_level |=> !o_wr.valid)
    else $error("Write issued while halted");

  a_seq_step: assert property (s_exec_plain |=>
    (pc == 13'($past(pc) + PC_STEP)) && (o_addr == pc))
    else $error("Plain instruction did not advance counter");

  a_transmit_literal_reg: assert property (exec && dec.is_transmit_literal && !dec.sel_io |=>
    o_wr.valid && (o_wr.data == $past(dec.lit)))
    else $error("Register transmit wrote wrong data");

  a_no_stray_write: assert property (!(exec && dec.is_transmit_literal) |=>
    !o_wr.valid)
    else $error("Write strobe without transmit");

  a_xec_reg_high: assert property (s_exec_xec ##0 !dec.sel_io |=>
    o_addr[ADDR_W-1:REG_SPAN_W] == $past(o_addr[ADDR_W-1:REG_SPAN_W]))
    else $error("Indirect on register changed high bits");

  a_prime_pulse: assert property (state == ST_PRIME |=>
    o_mclk && (state == ST_RUN) && $stable(pc))
    else $error("No clock pulse after reset release");

  a_transmit_literal_width: assert property (o_wr.valid && o_wr.io |->
    o_wr.data[DATA_W-1:IO_SPAN_W] == 3'h0)
    else $error("I/O transmit wider than five bits");

  a_reset_zero: assert property (@(posedge i_core_clk)
    disable iff (1'b0) !i_reset_n |-> (pc == PC_RST) &&
    (o_addr == AR_RST) && !o_mclk)
    else $error("Reset did not clear counter, address or clock");

endmodule // bxh_flow

//--- verification/bxh_mem.sv
`timescale 1ns/1ps
module bxh_mem
  import bxh_pkg::*;
(
  // Address from the core
  input wire logic [ADDR_W-1:0] i_addr,
  // Instruction word back
  output logic [INSTR_W-1:0] o_instr
);
  logic [INSTR_W-1:0] mem [0:(1<<ADDR_W)-1];
  // Combinational read, so the word is valid in the same cycle
  assign o_instr = mem[i_addr];
endmodule // bxh_mem

//--- verification/branch_execute_halt_reset_tb.sv
`timescale 1ns/1ps
module branch_execute_halt_reset_tb;
  import bxh_pkg::*;
  logic i_core_clk;
  logic i_reset_n;
  logic i_halt_n;
  logic [INSTR_W-1:0] instr;
  logic [DATA_W-1:0] src;
  logic [ADDR_W-1:0] o_addr;
  logic [ADDR_W-1:0] o_pc;
  logic [ADDR_W-1:0] pc;
  logic [ADDR_W-1:0] ar;
  bxh_wr_t o_wr;
  logic o_mclk;
  logic o_halted;
  logic wr_v;
  logic last_mclk;
  logic [DATA_W-1:0] wr_d;
  int miscompares;
  int n_checks;

  bxh_flow dut (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_halt_n(i_halt_n),
    .i_instr(instr),
    .o_addr(o_addr),
    .i_src_raw(src),
    .o_wr(o_wr),
    .o_mclk(o_mclk),
    .o_halted(o_halted),
    .o_pc(o_pc)
  );

  bxh_mem mem_i (
    .i_addr(o_addr),
    .o_instr(instr)
  );

  initial
  begin
    i_core_clk = 1'b0;
    forever #20 i_core_clk = ~i_core_clk;
  end

  function automatic logic [7:0] fmask(input logic [2:0] len);
    fmask = (len == 3'h0) ? 8'hff : (8'hff >> (4'h8 - {1'b0, len}));
  endfunction

  task automatic chk_a(input logic [12:0] g, input logic [12:0] e);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_b(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One cycle: expectation from the bench's own copy of pc and address
  task automatic step();
    logic [15:0] w;
    logic [7:0] v;
    logic [7:0] s;
    logic run;
    logic [4:0] dst;
    w = mem_i.mem[ar];
    dst = w[12:8];
    run = (o_halted === 1'b0);
    v = w[12] ? ((src >> w[10:8]) & fmask(w[7:5])) : src;
    s = w[7:0] + v;
    wr_v = run && (w[15:13] == 3'h6);
    wr_d = w[12] ? ({3'h0, w[4:0]} & fmask(w[7:5])) : w[7:0];
    last_mclk = o_mclk;
    @(posedge i_core_clk);
    #1;
    if (run)
    begin
      case (w[15:13])
        3'h4: ar = w[12] ? {ar[12:5], s[4:0]} : {ar[12:8], s};
        3'h7: pc = w[12:0];
        3'h5:
        begin
          if (v != 8'h00)
            pc = w[12] ? {pc[12:5], w[4:0]} : {pc[12:8], w[7:0]};
          else
            pc = pc + 13'h0001;
        end
        default: pc = pc + 13'h0001;
      endcase
      if (w[15:13] != 3'h4)
        ar = pc;
    end
    chk_a(o_pc, pc);
    chk_a(o_addr, ar);
    chk_b({7'h00, o_wr.valid}, {7'h00, wr_v});
    if (wr_v)
    begin
      chk_b(o_wr.data, wr_d);
      chk_b({3'h0, o_wr.dest}, {3'h0, dst});
      chk_b({5'h00, o_wr.len}, {5'h00, w[7:5]});
    end
    chk_b({7'h00, o_mclk}, {7'h00, ~last_mclk});
  endtask

  task automatic run(input int n);
    for (int i = 0; i < n; i++)
    begin
      src = 8'($urandom);
      step();
    end
  endtask

  // Release reset; the first edge only primes, nothing executes
  task automatic start();
    i_reset_n = 1'b1;
    pc = 13'h0000;
    ar = 13'h0000;
    @(posedge i_core_clk);
    #1;
    chk_b({7'h00, o_mclk}, 8'h01);
    chk_a(o_pc, 13'h0000);
  endtask

  initial
  begin
    void'($urandom(32'hd95dcaf1));
    i_reset_n = 1'b0;
    i_halt_n = 1'b1;
    src = 8'h00;
    miscompares = 0;
    n_checks = 0;
    for (int i = 0; i < 8192; i++)
      mem_i.mem[i] = 16'($urandom);
    // Corner: jump to the top address, then wrap past it
    mem_i.mem[0] = 16'hffff;
    repeat (8) @(posedge i_core_clk);
    #1;
    chk_a(o_pc, 13'h0000);
    chk_b({7'h00, o_mclk}, 8'h00);
    start();
    run(600);
    i_halt_n = 1'b0;
    run(4);
    chk_b({7'h00, o_halted}, 8'h01);
    run(12);
    i_halt_n = 1'b1;
    run(4);
    chk_b({7'h00, o_halted}, 8'h00);
    run(300);
    // Reset in mid-run takes effect without a clock edge; held a full cycle
    // so the far side keeps its minimum low time
    i_reset_n = 1'b0;
    #1;
    chk_a(o_pc, 13'h0000);
    chk_a(o_addr, 13'h0000);
    @(posedge i_core_clk);
    #1;
    chk_b({7'h00, o_mclk}, 8'h00);
    start();
    run(600);
    finish_test();
  end
endmodule // branch_execute_halt_reset_tb
